// File: src/cmsd_pkg.sv
package cmsd_pkg;

    // Program space
    localparam logic [15:0] FLASH_TOP      = 16'h1DFF;
    localparam logic [7:0]  FILL_VALUE     = 8'hFF;

    // Data space boundaries
    localparam logic [3:0]  BIT_WIN_HI     = 4'h2;
    localparam logic [7:0]  SFR_BASE       = 8'h80;
    localparam int          XRAM_BYTES     = 512;

    // Locally held special function registers
    localparam logic [7:0]  ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0]  ADDR_PSC       = 8'h8F;
    localparam logic [7:0]  ADDR_PSW       = 8'hD0;
    localparam logic [7:0]  STACK_RESET    = 8'h07;
    localparam logic [7:0]  PSC_RESET      = 8'h00;
    localparam logic [7:0]  PSW_RESET      = 8'h00;
    localparam int          PSC_WEN_BIT    = 0;
    localparam int          PSW_BANK_LO    = 3;
    localparam int          PSW_BANK_HI    = 4;

    // Occupied special function addresses, bit n = address 0x80 + n
    localparam logic [127:0] SFR_MAP = 128'hFFDFFF5F3FB33D7FFFCE3F7FBF7FFF8F;

    // Access kinds issued by the datapath
    localparam logic [2:0]  OP_CODE        = 3'h0;
    localparam logic [2:0]  OP_DIRECT      = 3'h1;
    localparam logic [2:0]  OP_INDIRECT    = 3'h2;
    localparam logic [2:0]  OP_BIT         = 3'h3;
    localparam logic [2:0]  OP_EXTERNAL_DATA_SPACE       = 3'h4;
    localparam logic [2:0]  OP_PUSH        = 3'h5;
    localparam logic [2:0]  OP_POP         = 3'h6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXT  = 2'b10
    } cmsd_state_t;

endpackage

// File: src/cmsd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Program space is 64 kB; addresses above flash top are reserved.
// - Flash occupies one contiguous region from zero to the flash top.
// - Program writes only via external data move with store-enable bit set.
// - 256 bytes internal data RAM across the whole byte address range.
// - Lower 128 bytes answer direct and indirect accesses.
// - Upper 128 bytes indirect and stack only, separate from special registers.
// - Above 0x7F, direct goes to special registers, indirect to upper RAM.
// - 512 bytes extra RAM in external data space, external move only.
// - Lowest 32 bytes are four banks of eight, chosen by status bits 3,4.
// - Indirect pointer comes from index register zero or one of active bank.
// - Bit window 0x20-0x2F holds 128 bits, address is 8*offset plus position.
// - Bit or byte access is chosen by the instruction's operand kind.
// - Stack pointer holds last used slot; push writes pointer+1 then increments.
// - Reset loads stack pointer with seven.
// - Stack anywhere in internal RAM, pointer wraps within byte range.
// - Direct addresses 0x80-0xFF select special function registers.
// - Special registers at low nibble 0 or 8 take bit and byte accesses.
module cmsd_decoder
    import cmsd_pkg::*;
#(
    parameter int XRAM_DEPTH = XRAM_BYTES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Datapath request
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_op,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic        req_idx_sel,
    input  wire logic [7:0]  req_wdata,
    output logic             req_ready_q,
    // Datapath answer
    output logic             resp_valid_q,
    output logic [7:0]       resp_rdata_q,
    output logic             resp_reserved_q,
    // Flash store port
    output logic             flash_rd_q,
    output logic             flash_wr_q,
    output logic [15:0]      flash_addr_q,
    output logic [7:0]       flash_wdata_q,
    input  wire logic [7:0]  flash_rdata,
    // Peripheral special register port
    output logic             sfr_sel_q,
    output logic             sfr_wr_q,
    output logic             sfr_bit_q,
    output logic [2:0]       sfr_bitpos_q,
    output logic [7:0]       sfr_addr_q,
    output logic [7:0]       sfr_wdata_q,
    input  wire logic [7:0]  sfr_rdata,
    // Locally held registers
    output logic [7:0]       stack_top_pointer_q,
    output logic [7:0]       program_store_control_q,
    output logic [7:0]       program_status_word_q
);

    localparam int XW = $clog2(XRAM_DEPTH);

    // Replace one bit of a byte
    function automatic logic [7:0] bit_merge(input logic [7:0] b, input logic [2:0] p,
                                             input logic v);
        logic [7:0] r;
        r    = b;
        r[p] = v;
        return r;
    endfunction

    cmsd_state_t state_q;
    cmsd_state_t state_d;
    logic [7:0]  ram_q  [0:255];
    logic [7:0]  xram_q [0:XRAM_DEPTH-1];

    // Request kind
    wire take      = req_valid & req_ready_q & (state_q == ST_IDLE);
    wire is_code   = (req_op == OP_CODE);
    wire is_dir    = (req_op == OP_DIRECT);
    wire is_ind    = (req_op == OP_INDIRECT);
    wire is_bit    = (req_op == OP_BIT);
    wire is_external_data_space  = (req_op == OP_EXTERNAL_DATA_SPACE);
    wire is_push   = (req_op == OP_PUSH);
    wire is_pop    = (req_op == OP_POP);

    // Index pointer from the active bank
    wire [1:0] bank      = program_status_word_q[PSW_BANK_HI:PSW_BANK_LO];
    wire [7:0] idx_addr  = {3'b000, bank, 2'b00, req_idx_sel};
    wire [7:0] ind_addr  = ram_q[idx_addr];

    // Bit address to byte address and bit position
    wire       bit_low   = ~req_addr[7];
    wire [7:0] bit_byte  = bit_low ? {BIT_WIN_HI, req_addr[6:3]}
                                   : {req_addr[7:3], 3'b000};
    wire [2:0] bitpos    = req_addr[2:0];

    // Effective data byte address
    wire [7:0] sp_inc    = stack_top_pointer_q + 8'h01;
    wire [7:0] sp_dec    = stack_top_pointer_q - 8'h01;
    wire [7:0] eff_addr  = is_ind  ? ind_addr :
                           is_bit  ? bit_byte :
                           is_push ? sp_inc :
                           is_pop  ? stack_top_pointer_q : req_addr[7:0];

    // Route to internal RAM or special register space
    wire dir_low   = is_dir & (req_addr[7:0] < SFR_BASE);
    wire to_ram    = dir_low | is_ind | is_push | is_pop | (is_bit & bit_low);
    wire to_sfr    = (is_dir & ~dir_low) | (is_bit & ~bit_low);
    wire sfr_occ   = SFR_MAP[eff_addr[6:0]];
    wire hit_sp    = to_sfr & (eff_addr == ADDR_STACK_TOP);
    wire hit_psc   = to_sfr & (eff_addr == ADDR_PSC);
    wire hit_psw   = to_sfr & (eff_addr == ADDR_PSW);
    wire hit_loc   = hit_sp | hit_psc | hit_psw;
    wire sfr_ext   = to_sfr & sfr_occ & ~hit_loc;
    wire sfr_rsvd  = to_sfr & ~sfr_occ;

    // Program and external data space
    wire code_in   = (req_addr <= FLASH_TOP);
    wire code_rd   = is_code & ~req_write & code_in;
    wire prog_wr   = is_external_data_space & req_write & program_store_control_q[PSC_WEN_BIT];
    wire flash_wgo = prog_wr & code_in;
    wire xram_in   = (req_addr < 16'(XRAM_DEPTH));
    wire xram_acc  = is_external_data_space & ~prog_wr & xram_in;
    wire [XW-1:0] xaddr = req_addr[XW-1:0];
    wire code_rsvd = (is_code & ~code_rd) | (prog_wr & ~code_in)
                   | (is_external_data_space & ~prog_wr & ~xram_in);
    wire ext_go    = take & (code_rd | flash_wgo | sfr_ext);

    // Byte seen at the effective address and its modified form
    wire [7:0] loc_rd   = hit_sp  ? stack_top_pointer_q :
                          hit_psc ? program_store_control_q :
                          hit_psw ? program_status_word_q : FILL_VALUE;
    wire [7:0] byte_in  = to_ram ? ram_q[eff_addr] : loc_rd;
    wire       bit_val  = byte_in[bitpos];
    wire [7:0] new_byte = is_bit ? bit_merge(byte_in, bitpos, req_wdata[0])
                                 : req_wdata;

    // Internal write strobes
    wire ram_we  = take & to_ram & (req_write | is_push) & ~is_pop;
    wire xram_we = take & xram_acc & req_write;
    wire loc_we  = take & hit_loc & req_write;

    // Answer data for accesses served here
    wire [7:0] int_rdata = (code_rsvd | sfr_rsvd) ? FILL_VALUE :
                           xram_acc ? xram_q[xaddr] :
                           is_push  ? 8'h00 :
                           is_bit   ? {7'h00, bit_val} : byte_in;

    // Next value of locally held registers
    wire [7:0] sp_d  = (take & is_push) ? sp_inc :
                       (take & is_pop)  ? sp_dec :
                       (loc_we & hit_sp) ? new_byte : stack_top_pointer_q;
    wire [7:0] psc_d = (loc_we & hit_psc) ? new_byte : program_store_control_q;
    wire [7:0] psw_d = (loc_we & hit_psw) ? new_byte : program_status_word_q;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (ext_go) begin
                    state_d = ST_EXT;
                end
            end
            ST_EXT: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer and handshake
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q         <= ST_IDLE;
            req_ready_q     <= 1'b1;
            resp_valid_q    <= 1'b0;
            resp_rdata_q    <= 8'h00;
            resp_reserved_q <= 1'b0;
        end else begin
            state_q         <= state_d;
            req_ready_q     <= (state_d == ST_IDLE);
            resp_valid_q    <= (take & ~ext_go) | (state_q == ST_EXT);
            resp_rdata_q    <= (state_q == ST_EXT) ? (flash_rd_q ? flash_rdata : sfr_rdata)
                                                   : int_rdata;
            resp_reserved_q <= take & (code_rsvd | sfr_rsvd);
        end
    end

    // Strobes toward flash and peripheral registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_rd_q    <= 1'b0;
            flash_wr_q    <= 1'b0;
            flash_addr_q  <= 16'h0000;
            flash_wdata_q <= 8'h00;
            sfr_sel_q     <= 1'b0;
            sfr_wr_q      <= 1'b0;
            sfr_bit_q     <= 1'b0;
            sfr_bitpos_q  <= 3'h0;
            sfr_addr_q    <= 8'h00;
            sfr_wdata_q   <= 8'h00;
        end else begin
            flash_rd_q    <= take & code_rd;
            flash_wr_q    <= take & flash_wgo;
            flash_addr_q  <= ext_go ? req_addr : flash_addr_q;
            flash_wdata_q <= ext_go ? req_wdata : flash_wdata_q;
            sfr_sel_q     <= take & sfr_ext;
            sfr_wr_q      <= take & sfr_ext & req_write;
            sfr_bit_q     <= take & sfr_ext & is_bit;
            sfr_bitpos_q  <= ext_go ? bitpos : sfr_bitpos_q;
            sfr_addr_q    <= ext_go ? eff_addr : sfr_addr_q;
            sfr_wdata_q   <= ext_go ? req_wdata : sfr_wdata_q;
        end
    end

    // Locally held registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_top_pointer_q     <= STACK_RESET;
            program_store_control_q <= PSC_RESET;
            program_status_word_q   <= PSW_RESET;
        end else begin
            stack_top_pointer_q     <= sp_d;
            program_store_control_q <= psc_d;
            program_status_word_q   <= psw_d;
        end
    end

    // Storage arrays, not reset
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram_q[eff_addr] <= is_push ? req_wdata : new_byte;
        end
        if (xram_we) begin
            xram_q[xaddr] <= req_wdata;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    push_step_a: assert property (take && is_push |=>
        stack_top_pointer_q == $past(stack_top_pointer_q) + 8'h01)
        else $error("push did not advance the stack pointer");

    push_data_a: assert property (take && is_push |=>
        ram_q[$past(stack_top_pointer_q) + 8'h01] == $past(req_wdata))
        else $error("push byte not stored above the old pointer");

    pop_step_a: assert property (take && is_pop |=>
        stack_top_pointer_q == $past(stack_top_pointer_q) - 8'h01 &&
        resp_rdata_q == ram_q[$past(stack_top_pointer_q)])
        else $error("pop did not return top byte and step down");

    code_rsvd_a: assert property (take && is_code && req_addr > FLASH_TOP |=>
        resp_valid_q && resp_reserved_q && resp_rdata_q == FILL_VALUE && !flash_rd_q)
        else $error("reserved program address not answered with fill");

    flash_gate_a: assert property (flash_wr_q |->
        $past(program_store_control_q[PSC_WEN_BIT]) && $past(req_op) == OP_EXTERNAL_DATA_SPACE)
        else $error("flash write without store enable and external move");

    ext_lat_a: assert property (ext_go |=> !resp_valid_q ##1 resp_valid_q && req_ready_q)
        else $error("external access not answered two cycles after take");

    int_lat_a: assert property (take && !ext_go |=> resp_valid_q && req_ready_q)
        else $error("internal access not answered in one cycle");

    // A reserved address leaves the port quiet, so its address is not compared
    dir_high_a: assert property (take && is_dir && req_addr[7] && !hit_loc |=>
        (sfr_sel_q == $past(sfr_occ)) &&
        (!$past(sfr_occ) || sfr_addr_q == $past(req_addr[7:0])))
        else $error("direct upper access not sent to special registers");

    ind_high_a: assert property (take && is_ind && req_write |=>
        ram_q[$past(ind_addr)] == $past(req_wdata) && !sfr_sel_q)
        else $error("indirect write not stored in internal RAM");

    sfr_bit_a: assert property (sfr_bit_q |-> sfr_addr_q[2:0] == 3'h0)
        else $error("bit access sent to byte-only special register");

    // Pointer byte sits at eight times the active bank plus the index select
    bank_ptr_a: assert property (take && is_ind |->
        ind_addr == ram_q[8'(program_status_word_q[PSW_BANK_HI:PSW_BANK_LO]) * 8'h08
                          + 8'(req_idx_sel)])
        else $error("index register taken from the wrong bank");

    bit_win_a: assert property (take && is_bit && !req_write && bit_low |=>
        resp_rdata_q == {7'h00, ram_q[{BIT_WIN_HI, $past(req_addr[6:3])}][$past(bitpos)]})
        else $error("bit window read returned the wrong bit");

    // Reset leaves the pointer on the last byte of bank zero
    reset_sp_a: assert property ($rose(arst_n) |->
        stack_top_pointer_q == STACK_RESET && program_store_control_q == PSC_RESET &&
        program_status_word_q == PSW_RESET)
        else $error("locally held registers not at reset values");

    // Lower half of the byte space is plain RAM for direct writes
    dir_low_a: assert property (take && is_dir && !req_addr[7] && req_write |=>
        ram_q[$past(req_addr[7:0])] == $past(req_wdata) && !sfr_sel_q)
        else $error("direct lower write not stored in internal RAM");

    // Status word byte writes land whole, bank bits included
    psw_wr_a: assert property (take && hit_psw && req_write && !is_bit |=>
        program_status_word_q == $past(req_wdata))
        else $error("status word write lost");

    // Bit address in special space picks the register at its aligned byte
    bit_reg_a: assert property (take && is_bit && req_addr[7] &&
        sfr_occ && !hit_loc |=> sfr_sel_q && sfr_bit_q &&
        sfr_addr_q == {$past(req_addr[7:3]), 3'h0} && sfr_bitpos_q == $past(req_addr[2:0]))
        else $error("special register bit access mapped to the wrong place");

    // Extra RAM keeps what the external move wrote
    xram_wr_a: assert property (take && xram_acc && req_write |=>
        xram_q[$past(xaddr)] == $past(req_wdata) && !flash_wr_q)
        else $error("external move write not stored in extra RAM");

    // In-range code reads go out on the flash port with the full address
    code_rd_a: assert property (take && is_code && !req_write &&
        req_addr <= FLASH_TOP |=> flash_rd_q && flash_addr_q == $past(req_addr))
        else $error("program read not sent to flash");

    // Reserved accesses must not disturb any stored state
    rsvd_quiet_a: assert property (take && (code_rsvd || sfr_rsvd) |=>
        !flash_wr_q && !sfr_sel_q && $stable(stack_top_pointer_q) &&
        $stable(program_store_control_q) && $stable(program_status_word_q))
        else $error("reserved access changed stored state");

    push_cov_c: cover property (take && is_push ##1 take && is_pop);
    rsvd_cov_c: cover property (resp_valid_q && resp_reserved_q);
    flash_cov_c: cover property (flash_wr_q);
    sfr_bit_cov_c: cover property (sfr_bit_q && sfr_wr_q);
    xram_cov_c: cover property (take && xram_acc && req_write);

endmodule

`default_nettype wire

// File: tb/cmsd_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmsd_far_model (
    // Clock
    input  wire logic        core_clk,
    // Flash store port
    input  wire logic        flash_rd_q,
    input  wire logic        flash_wr_q,
    input  wire logic [15:0] flash_addr_q,
    input  wire logic [7:0]  flash_wdata_q,
    output logic [7:0]       flash_rdata,
    // Peripheral special register port
    input  wire logic        sfr_sel_q,
    input  wire logic        sfr_wr_q,
    input  wire logic        sfr_bit_q,
    input  wire logic [2:0]  sfr_bitpos_q,
    input  wire logic [7:0]  sfr_addr_q,
    input  wire logic [7:0]  sfr_wdata_q,
    output logic [7:0]       sfr_rdata
);
    logic [7:0] flash_mem [0:8191];
    logic [7:0] sfr_mem   [0:127];
    logic       tog;

    // Preset flash with an address pattern, peripheral registers cleared
    initial begin
        tog = 1'b0;
        for (int i = 0; i < 8192; i++) flash_mem[i] = i[7:0] ^ 8'h5A;
        for (int i = 0; i < 128; i++) sfr_mem[i] = 8'h00;
    end

    // Store writes; bit writes modify one bit of the peripheral register
    always @(posedge core_clk) begin
        tog <= ~tog;
        if (flash_wr_q) flash_mem[flash_addr_q[12:0]] <= flash_wdata_q;
        if (sfr_sel_q && sfr_wr_q && sfr_bit_q) sfr_mem[sfr_addr_q[6:0]][sfr_bitpos_q] <= sfr_wdata_q[0];
        else if (sfr_sel_q && sfr_wr_q) sfr_mem[sfr_addr_q[6:0]] <= sfr_wdata_q;
    end

    // Data only while strobed; otherwise a pattern that changes every cycle
    assign flash_rdata = flash_rd_q ? flash_mem[flash_addr_q[12:0]] : {8{tog}};
    assign sfr_rdata   = !sfr_sel_q ? {8{~tog}} :
                         sfr_bit_q ? {7'h00, sfr_mem[sfr_addr_q[6:0]][sfr_bitpos_q]} :
                         sfr_mem[sfr_addr_q[6:0]];
endmodule

`default_nettype wire

// File: tb/core_memory_space_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module core_memory_space_decoder_tb_top;
    import cmsd_pkg::*;
    logic core_clk, arst_n, req_valid, req_write, req_idx_sel;
    logic [2:0] req_op;
    logic [15:0] req_addr;
    logic [7:0] req_wdata, flash_rdata, sfr_rdata, got_d;
    logic req_ready_q, resp_valid_q, resp_reserved_q, flash_rd_q, flash_wr_q, got_rs;
    logic sfr_sel_q, sfr_wr_q, sfr_bit_q;
    logic [7:0] resp_rdata_q, flash_wdata_q, sfr_addr_q, sfr_wdata_q;
    logic [15:0] flash_addr_q;
    logic [2:0] sfr_bitpos_q;
    logic [7:0] stack_top_pointer_q, program_store_control_q, program_status_word_q;
    int error_cnt = 0;
    int n_tests = 0;

    cmsd_decoder DUT (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_op(req_op), .req_write(req_write), .req_addr(req_addr), .req_idx_sel(req_idx_sel),
        .req_wdata(req_wdata), .req_ready_q(req_ready_q), .resp_valid_q(resp_valid_q),
        .resp_rdata_q(resp_rdata_q), .resp_reserved_q(resp_reserved_q), .flash_rd_q(flash_rd_q),
        .flash_wr_q(flash_wr_q), .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q),
        .flash_rdata(flash_rdata), .sfr_sel_q(sfr_sel_q), .sfr_wr_q(sfr_wr_q),
        .sfr_bit_q(sfr_bit_q), .sfr_bitpos_q(sfr_bitpos_q), .sfr_addr_q(sfr_addr_q),
        .sfr_wdata_q(sfr_wdata_q), .sfr_rdata(sfr_rdata), .stack_top_pointer_q(stack_top_pointer_q),
        .program_store_control_q(program_store_control_q),
        .program_status_word_q(program_status_word_q));

    cmsd_far_model far (.core_clk(core_clk), .flash_rd_q(flash_rd_q), .flash_wr_q(flash_wr_q),
        .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q), .flash_rdata(flash_rdata),
        .sfr_sel_q(sfr_sel_q), .sfr_wr_q(sfr_wr_q), .sfr_bit_q(sfr_bit_q),
        .sfr_bitpos_q(sfr_bitpos_q), .sfr_addr_q(sfr_addr_q), .sfr_wdata_q(sfr_wdata_q),
        .sfr_rdata(sfr_rdata));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Print the counts and the verdict, then stop
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One datapath access: hold until taken, then wait a bounded time for the answer
    task automatic go(input logic [2:0] op, input logic wr, input logic [15:0] a,
                      input logic idx, input logic [7:0] wd);
        int n;
        n = 0;
        // Let one edge pass so valid never drops and rises in one time step
        @(negedge core_clk);
        while (req_ready_q !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (req_ready_q !== 1'b1) begin
            error_cnt++;
            $display("Error ready timeout expected 1 seen 0");
            summarize();
        end
        req_valid = 1'b1;
        req_op = op;
        req_write = wr;
        req_addr = a;
        req_idx_sel = idx;
        req_wdata = wd;
        @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (resp_valid_q !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        if (resp_valid_q !== 1'b1) begin
            error_cnt++;
            $display("Error answer timeout expected 1 seen 0");
            summarize();
        end
        got_d = resp_rdata_q;
        got_rs = resp_reserved_q;
    endtask

    // Read and judge data and reserved flag
    task automatic rd(input logic [2:0] op, input logic [15:0] a, input logic idx,
                      input logic [7:0] e, input logic ers);
        go(op, 1'b0, a, idx, 8'h00);
        `CHK("read data", e, got_d)
        `CHK("reserved flag", ers, got_rs)
    endtask

    // Reset values, mid-run reset and the first push
    task automatic t_reset();
        `CHK("stack pointer", 8'h07, stack_top_pointer_q)
        `CHK("store control", 8'h00, program_store_control_q)
        go(OP_DIRECT, 1'b1, 16'h0081, 1'b0, 8'h20);
        @(negedge core_clk);
        arst_n = 1'b0;
        @(negedge core_clk);
        arst_n = 1'b1;
        rd(OP_DIRECT, 16'h0081, 1'b0, 8'h07, 1'b0);
        go(OP_PUSH, 1'b0, 16'h0000, 1'b0, 8'hC3);
        rd(OP_DIRECT, 16'h0008, 1'b0, 8'hC3, 1'b0);
        `CHK("stack pointer", 8'h08, stack_top_pointer_q)
        $display("test reset done");
    endtask

    // Banks, index registers, upper RAM against special registers
    task automatic t_banks();
        go(OP_DIRECT, 1'b1, 16'h0090, 1'b0, 8'h3C);
        go(OP_DIRECT, 1'b1, 16'h00D0, 1'b0, 8'h18);
        `CHK("bank bits", 8'h18, program_status_word_q)
        go(OP_DIRECT, 1'b1, 16'h0019, 1'b0, 8'h90);
        go(OP_INDIRECT, 1'b1, 16'h0000, 1'b1, 8'hA5);
        rd(OP_DIRECT, 16'h0090, 1'b0, 8'h3C, 1'b0);
        rd(OP_INDIRECT, 16'h0000, 1'b1, 8'hA5, 1'b0);
        go(OP_DIRECT, 1'b1, 16'h00D0, 1'b0, 8'h00);
        go(OP_DIRECT, 1'b1, 16'h0000, 1'b0, 8'h40);
        go(OP_DIRECT, 1'b1, 16'h0040, 1'b0, 8'h77);
        rd(OP_INDIRECT, 16'h0000, 1'b0, 8'h77, 1'b0);
        rd(OP_DIRECT, 16'h0019, 1'b0, 8'h90, 1'b0);
        $display("test banks done");
    endtask

    // Bit window, local and peripheral bit-addressable registers
    task automatic t_bits();
        go(OP_DIRECT, 1'b1, 16'h0022, 1'b0, 8'h00);
        go(OP_BIT, 1'b1, 16'h0013, 1'b0, 8'h01);
        rd(OP_DIRECT, 16'h0022, 1'b0, 8'h08, 1'b0);
        rd(OP_BIT, 16'h0013, 1'b0, 8'h01, 1'b0);
        go(OP_BIT, 1'b1, 16'h00D3, 1'b0, 8'h01);
        `CHK("bank bits", 8'h08, program_status_word_q)
        go(OP_BIT, 1'b1, 16'h0090, 1'b0, 8'h01);
        rd(OP_DIRECT, 16'h0090, 1'b0, 8'h3D, 1'b0);
        go(OP_DIRECT, 1'b1, 16'h00D0, 1'b0, 8'h00);
        $display("test bits done");
    endtask

    // Stack wraps within the byte range
    task automatic t_stack();
        go(OP_DIRECT, 1'b1, 16'h0081, 1'b0, 8'hFF);
        go(OP_PUSH, 1'b0, 16'h0000, 1'b0, 8'h5A);
        `CHK("stack pointer", 8'h00, stack_top_pointer_q)
        rd(OP_DIRECT, 16'h0000, 1'b0, 8'h5A, 1'b0);
        rd(OP_POP, 16'h0000, 1'b0, 8'h5A, 1'b0);
        `CHK("stack pointer", 8'hFF, stack_top_pointer_q)
        $display("test stack done");
    endtask

    // Program space, write gating, extra RAM and reserved places
    task automatic t_program();
        rd(OP_CODE, 16'h1DFF, 1'b0, 8'hFF ^ 8'h5A, 1'b0);
        rd(OP_CODE, 16'h1E00, 1'b0, FILL_VALUE, 1'b1);
        go(OP_EXTERNAL_DATA_SPACE, 1'b1, 16'h01FF, 1'b0, 8'h66);
        rd(OP_EXTERNAL_DATA_SPACE, 16'h01FF, 1'b0, 8'h66, 1'b0);
        rd(OP_CODE, 16'h0010, 1'b0, 8'h4A, 1'b0);
        rd(OP_EXTERNAL_DATA_SPACE, 16'h0200, 1'b0, FILL_VALUE, 1'b1);
        go(OP_DIRECT, 1'b1, 16'h008F, 1'b0, 8'h01);
        go(OP_EXTERNAL_DATA_SPACE, 1'b1, 16'h0010, 1'b0, 8'h12);
        rd(OP_CODE, 16'h0010, 1'b0, 8'h12, 1'b0);
        rd(OP_EXTERNAL_DATA_SPACE, 16'h01FF, 1'b0, 8'h66, 1'b0);
        go(OP_EXTERNAL_DATA_SPACE, 1'b1, 16'h1E00, 1'b0, 8'h34);
        `CHK("reserved flag", 1'b1, got_rs)
        go(OP_CODE, 1'b1, 16'h0011, 1'b0, 8'h00);
        `CHK("reserved flag", 1'b1, got_rs)
        go(OP_DIRECT, 1'b1, 16'h008F, 1'b0, 8'h00);
        // Deliberate touch of an unoccupied special address
        go(OP_DIRECT, 1'b1, 16'h0084, 1'b0, 8'h55);
        rd(OP_DIRECT, 16'h0084, 1'b0, FILL_VALUE, 1'b1);
        $display("test program done");
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_op = OP_CODE;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_idx_sel = 1'b0;
        req_wdata = 8'h00;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        t_reset();
        t_banks();
        t_bits();
        t_stack();
        t_program();
        summarize();
    end
endmodule

`default_nettype wire
